// ---- hw/lv_buck_pkg.sv ----
package lv_buck_pkg;
	// Register indices of the plain register port.
	localparam logic [3:0] ADDR_STATUS = 4'h0;
	localparam logic [3:0] ADDR_MASK = 4'h1;
	localparam logic [3:0] ADDR_LIVE = 4'h2;
	localparam logic [3:0] ADDR_VSET = 4'h3;
	localparam logic [3:0] ADDR_VSETN = 4'h4;
	localparam logic [3:0] ADDR_DETECT = 4'h5;
	localparam logic [3:0] ADDR_CTRL = 4'h6;
	// Sticky status bit positions.
	localparam int BIT_OCTO = 0;
	localparam int BIT_OTW = 1;
	localparam int BIT_OTSD = 2;
	localparam int BIT_TSDEV = 3;
	localparam int NUM_EVENTS = 4;
	// Control register bit positions.
	localparam int BIT_EN = 0;
	localparam int BIT_EXTSYNC = 1;
	// Voltage code: target = 0.9 V + code * 50 mV, codes 0..8.
	localparam int VSTEP_MV = 50;
	localparam int VMIN_MV = 900;
	localparam int VMAX_MV = 1300;
	localparam logic [7:0] VCODE_MAX = 8'((VMAX_MV - VMIN_MV) / VSTEP_MV);
	localparam logic [7:0] VCODE_RESET = 8'h07;
	localparam logic [7:0] MASK_RESET = 8'h0f;
	localparam logic [7:0] CTRL_RESET = 8'h01;
	// Timing at 200 MHz.
	localparam int CLK_MHZ = 200;
	localparam int OC_TIMEOUT_US = 100;
	localparam int OC_TIMEOUT_CYC = OC_TIMEOUT_US * CLK_MHZ;
	localparam int PERIOD_CYC = 91;
	localparam int SOFTSTART_STEP_CYC = 64;
endpackage

// ---- hw/sw_period_gen.sv ----
`timescale 1ns/1ps
module sw_period_gen #(
	parameter int PERIOD = lv_buck_pkg::PERIOD_CYC
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_n,
	// Sync sources.
	input wire logic sharedSync,
	input wire logic extSync,
	input wire logic useExt,
	// Period start pulse.
	output logic periodStart
);
	logic [15:0] cnt_q;
	logic extPrev_q;
	wire extRise = extSync & ~extPrev_q;
	wire wrap = (cnt_q == 16'(PERIOD - 1));
	// External edges restart the period; a missing edge falls back to wrap.
	wire restart = useExt ? (extRise | wrap) : (sharedSync | wrap);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 16'h0000;
			extPrev_q <= 1'b0;
		end else begin
			cnt_q <= restart ? 16'h0000 : cnt_q + 16'h0001;
			extPrev_q <= extSync;
		end
	end
	assign periodStart = restart;
endmodule // sw_period_gen

// ---- hw/oc_timeout.sv ----
`timescale 1ns/1ps
module oc_timeout #(
	parameter int TIMEOUT = lv_buck_pkg::OC_TIMEOUT_CYC
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_n,
	// Limiting activity.
	input wire logic limiting,
	// Expiry level, held high while limiting lasts.
	output logic expired
);
	logic [23:0] cnt_q;
	wire hit = (cnt_q == 24'(TIMEOUT - 1));

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			cnt_q <= 24'h000000;
		else if (!limiting)
			cnt_q <= 24'h000000;
		else if (!hit)
			cnt_q <= cnt_q + 24'h000001;
	end
	// Once expired the output stays high while limiting lasts, so a flag that
	// the host clears comes straight back if the overload is still there.
	assign expired = limiting & ((cnt_q == 24'(TIMEOUT - 2)) | hit);
endmodule // oc_timeout

// ---- hw/lv_buck_supervisor.sv ----
`timescale 1ns/1ps
// Operation
// - High-side switch turns off when peak-current comparator fires.
// - Low-side overcurrent at period end blocks next period's turn-on.
// - Limiting lasting the time-out sets sticky flag and interrupt.
// - Warning comparator sets sticky warning flag and interrupt.
// - Shutdown comparator disables regulator, pulses event, sets flag.
// - Shutdown flag stays set through shutdown for later reading.
// - Warning readable as live bit and as sticky bit.
// - Voltage changes accepted in active state via both registers.
// - Codes outside 0.9 V to 1.3 V are rejected.
// - One code step equals 50 mV.
// - Input-supply detector sampled before start decides used or unused.
// - Detection result held in readable availability flag.
// - Output ramps up gradually at start, under sequencing permission.
// - Period comes from shared clock or external sync input.
module lv_buck_supervisor #(
	parameter int OC_TIMEOUT = lv_buck_pkg::OC_TIMEOUT_CYC,
	parameter int PERIOD = lv_buck_pkg::PERIOD_CYC,
	parameter int SS_STEP = lv_buck_pkg::SOFTSTART_STEP_CYC
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_n,
	// Register port.
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	output logic irq,
	// Sequencing.
	input wire logic activeState,
	input wire logic seqStartOk,
	input wire logic supplyDetect,
	// Comparators.
	input wire logic peakLimit,
	input wire logic lsOvercurrent,
	input wire logic overtempWarn,
	input wire logic overtempShutdown,
	// Clocking.
	input wire logic sharedSync,
	input wire logic extSyncIn,
	// Power stage control.
	output logic hsOn,
	output logic regEnable,
	output logic [7:0] targetCode,
	output logic [7:0] softCode,
	output logic thermalShutdownEvent
);
	// All checks below run on the one clock and rest during reset.
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	typedef enum logic [3:0] {
		ST_DETECT = 4'b0001,
		ST_OFF = 4'b0010,
		ST_RAMP = 4'b0100,
		ST_RUN = 4'b1000
	} state_e;

	state_e state_q, state_d;
	logic [7:0] mask_q, vset_q, ctrl_q, soft_q, rdata_q;
	logic [lv_buck_pkg::NUM_EVENTS-1:0] status_q;
	logic avail_q, detDone_q, hs_q, lsBlock_q, tsd_q, otsdPrev_q;
	logic [15:0] ssCnt_q;

	wire periodStart;
	wire ocExpired;
	wire running = (state_q == ST_RAMP) | (state_q == ST_RUN);

	sw_period_gen #(.PERIOD(PERIOD)) u_period (
		.mclk(mclk),
		.rst_n(rst_n),
		.sharedSync(sharedSync),
		.extSync(extSyncIn),
		.useExt(ctrl_q[lv_buck_pkg::BIT_EXTSYNC]),
		.periodStart(periodStart)
	);

	// Limiting counts when either comparator holds off the high side.
	wire limiting = running & (peakLimit | lsBlock_q);
	oc_timeout #(.TIMEOUT(OC_TIMEOUT)) u_octo (
		.mclk(mclk),
		.rst_n(rst_n),
		.limiting(limiting),
		.expired(ocExpired)
	);

	// Register decode.
	function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
		return a == r;
	endfunction
	wire wrStatus = regWr & hit(regAddr, lv_buck_pkg::ADDR_STATUS);
	wire wrMask = regWr & hit(regAddr, lv_buck_pkg::ADDR_MASK);
	wire wrVset = regWr & hit(regAddr, lv_buck_pkg::ADDR_VSET);
	wire wrVsetn = regWr & hit(regAddr, lv_buck_pkg::ADDR_VSETN);
	wire wrCtrl = regWr & hit(regAddr, lv_buck_pkg::ADDR_CTRL);
	// The complement register must match the pending primary write, so the
	// primary is staged and committed only by a matching complement write.
	logic [7:0] vpend_q;
	wire vOk = (~regWdata == vpend_q) & (vpend_q <= lv_buck_pkg::VCODE_MAX);
	wire vCommit = wrVsetn & vOk & activeState;

	// Events, qualified by availability.
	logic [lv_buck_pkg::NUM_EVENTS-1:0] evt;
	assign evt[lv_buck_pkg::BIT_OCTO] = avail_q & ocExpired;
	assign evt[lv_buck_pkg::BIT_OTW] = avail_q & overtempWarn;
	assign evt[lv_buck_pkg::BIT_OTSD] = avail_q & overtempShutdown;
	assign evt[lv_buck_pkg::BIT_TSDEV] = avail_q & overtempShutdown
		& ~otsdPrev_q;
	wire [lv_buck_pkg::NUM_EVENTS-1:0] clr =
		wrStatus ? regWdata[lv_buck_pkg::NUM_EVENTS-1:0] : '0;
	wire [lv_buck_pkg::NUM_EVENTS-1:0] status_d = evt | (status_q & ~clr);

	// Start-up control.
	wire enReq = ctrl_q[lv_buck_pkg::BIT_EN] & seqStartOk;
	wire ssTick = (ssCnt_q == 16'(SS_STEP - 1));
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_DETECT: state_d = ST_OFF;
			ST_OFF: if (avail_q && enReq && !overtempShutdown)
				state_d = ST_RAMP;
			ST_RAMP: if (overtempShutdown || !enReq)
				state_d = ST_OFF;
			else if (soft_q >= vset_q)
				state_d = ST_RUN;
			ST_RUN: if (overtempShutdown || !enReq)
				state_d = ST_OFF;
			default: state_d = ST_DETECT;
		endcase
	end

	// High-side switch: on at period start unless blocked, off on peak limit.
	wire hsSet = running & periodStart & ~lsOvercurrent & ~peakLimit;
	wire hsClr = ~running | peakLimit | periodStart;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_DETECT;
			avail_q <= 1'b0;
			detDone_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (state_q == ST_DETECT && !detDone_q) begin
				avail_q <= supplyDetect;
				detDone_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hs_q <= 1'b0;
			lsBlock_q <= 1'b0;
		end else begin
			hs_q <= hsSet | (hs_q & ~hsClr);
			if (periodStart)
				lsBlock_q <= lsOvercurrent;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			soft_q <= 8'h00;
			ssCnt_q <= 16'h0000;
		end else if (state_q != ST_RAMP && state_q != ST_RUN) begin
			soft_q <= 8'h00;
			ssCnt_q <= 16'h0000;
		end else begin
			ssCnt_q <= ssTick ? 16'h0000 : ssCnt_q + 16'h0001;
			if (soft_q > vset_q)
				soft_q <= vset_q;
			else if (ssTick && soft_q < vset_q)
				soft_q <= soft_q + 8'h01;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			status_q <= '0;
			otsdPrev_q <= 1'b0;
			tsd_q <= 1'b0;
		end else begin
			status_q <= status_d;
			otsdPrev_q <= overtempShutdown;
			tsd_q <= evt[lv_buck_pkg::BIT_TSDEV];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mask_q <= lv_buck_pkg::MASK_RESET;
			ctrl_q <= lv_buck_pkg::CTRL_RESET;
			vset_q <= lv_buck_pkg::VCODE_RESET;
			vpend_q <= lv_buck_pkg::VCODE_RESET;
		end else begin
			if (wrMask)
				mask_q <= regWdata;
			if (wrCtrl)
				ctrl_q <= regWdata;
			if (wrVset)
				vpend_q <= regWdata;
			if (vCommit)
				vset_q <= vpend_q;
		end
	end

	// Read mux.
	logic [7:0] rdMux;
	always_comb begin
		unique case (regAddr)
			lv_buck_pkg::ADDR_STATUS: rdMux = 8'(status_q);
			lv_buck_pkg::ADDR_MASK: rdMux = mask_q;
			lv_buck_pkg::ADDR_LIVE: rdMux = {7'h00, overtempWarn};
			lv_buck_pkg::ADDR_VSET: rdMux = vset_q;
			lv_buck_pkg::ADDR_VSETN: rdMux = ~vset_q;
			lv_buck_pkg::ADDR_DETECT: rdMux = {7'h00, avail_q};
			lv_buck_pkg::ADDR_CTRL: rdMux = ctrl_q;
			default: rdMux = 8'h00;
		endcase
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			rdata_q <= 8'h00;
		else
			rdata_q <= regRd ? rdMux : 8'h00;
	end

	assign regRdata = rdata_q;
	assign irq = |(status_q & mask_q[lv_buck_pkg::NUM_EVENTS-1:0]);
	assign hsOn = hs_q;
	assign regEnable = running;
	assign targetCode = vset_q;
	assign softCode = soft_q;
	assign thermalShutdownEvent = tsd_q;

	// Checks.
	peak_off_a: assert property (peakLimit |=> !hsOn)
		else $error("high side on after peak");
	ls_block_a: assert property (
		(periodStart && lsOvercurrent) |=> !hsOn [*2])
		else $error("high side on after low-side overcurrent");
	oc_flag_a: assert property (
		evt[lv_buck_pkg::BIT_OCTO] |=> status_q[lv_buck_pkg::BIT_OCTO])
		else $error("timeout flag not set");
	warn_flag_a: assert property (
		(avail_q && overtempWarn) |=> status_q[lv_buck_pkg::BIT_OTW])
		else $error("warning flag not set");
	tsd_off_a: assert property (
		(avail_q && overtempShutdown) |=> !regEnable ##0
		status_q[lv_buck_pkg::BIT_OTSD])
		else $error("shutdown not taken");
	sd_hold_a: assert property (
		(status_q[lv_buck_pkg::BIT_OTSD] && !wrStatus)
		|=> status_q[lv_buck_pkg::BIT_OTSD])
		else $error("shutdown flag lost");
	vset_range_a: assert property (
		vset_q <= lv_buck_pkg::VCODE_MAX)
		else $error("voltage code out of range");
	vset_hold_a: assert property (
		!activeState |=> $stable(vset_q))
		else $error("voltage changed outside active");
	unused_quiet_a: assert property (
		(detDone_q && !avail_q) |-> (!regEnable && status_q == '0))
		else $error("unused regulator active");
	ramp_a: assert property (
		(state_q == ST_OFF && state_d == ST_RAMP) |=> softCode == 8'h00)
		else $error("ramp not from zero");
	tsd_pulse_a: assert property (
		thermalShutdownEvent |=> !thermalShutdownEvent)
		else $error("shutdown event longer than one cycle");
	avail_hold_a: assert property (
		detDone_q |=> $stable(avail_q))
		else $error("availability changed after detection");
	live_read_a: assert property (
		(regRd && regAddr == lv_buck_pkg::ADDR_LIVE)
		|=> regRdata == {7'h00, $past(overtempWarn)})
		else $error("live warning bit wrong");
	ls_sample_a: assert property (
		periodStart |=> lsBlock_q == $past(lsOvercurrent))
		else $error("low-side sample missed");
	hs_idle_a: assert property (!regEnable |=> !hsOn)
		else $error("high side on while regulator off");
	vcommit_a: assert property (
		vCommit |=> targetCode == $past(vpend_q))
		else $error("voltage commit lost");
	soft_step_a: assert property (
		(state_q == ST_RAMP && ssTick && soft_q < vset_q)
		|=> softCode == $past(softCode) + 8'h01)
		else $error("soft start step missed");
	cover_ramp_c: cover property (@(posedge mclk) state_q == ST_RUN);
	cover_ext_c: cover property (@(posedge mclk)
		periodStart && ctrl_q[lv_buck_pkg::BIT_EXTSYNC]);
	cover_oc_c: cover property (@(posedge mclk) ocExpired && avail_q);
	cover_tsd_c: cover property (@(posedge mclk) thermalShutdownEvent);
	cover_vset_c: cover property (@(posedge mclk) vCommit);
endmodule // lv_buck_supervisor

// ---- testbench/host_model.sv ----
`timescale 1ns/1ps
module host_model #(
	parameter int SETTLE = 4
) (
	// Clock.
	input wire logic mclk,
	// Register port.
	output logic [3:0] regAddr,
	output logic [7:0] regWdata,
	output logic regWr,
	output logic regRd,
	input wire logic [7:0] regRdata
);
	initial begin
		regAddr = 4'h0;
		regWdata = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
	end

	// A spare cycle follows each strobe so no strobe is set twice in a step.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		// The data stand only in this cycle; take them mid-cycle.
		@(negedge mclk);
		d = regRdata;
		@(posedge mclk);
	endtask

	// The caller moves one code at a time and decides any reaction to faults.
	task automatic step(input logic [7:0] code);
		wr(lv_buck_pkg::ADDR_VSET, code);
		wr(lv_buck_pkg::ADDR_VSETN, ~code);
		repeat (SETTLE) @(posedge mclk);
	endtask
endmodule // host_model

// ---- testbench/test_lv_buck_supervisor.sv ----
`timescale 1ns/1ps
module test_lv_buck_supervisor;
	localparam logic [3:0] ST = lv_buck_pkg::ADDR_STATUS;
	localparam logic [3:0] MK = lv_buck_pkg::ADDR_MASK;
	localparam logic [3:0] LV = lv_buck_pkg::ADDR_LIVE;
	logic mclk, rst_n, regWr, regRd, irq, hsOn, regEnable, tsdEvent;
	logic activeState, seqStartOk, supplyDetect, peakLimit, lsOvercurrent;
	logic overtempWarn, overtempShutdown, sharedSync, extSyncIn;
	logic [3:0] regAddr;
	logic [7:0] regWdata, regRdata, targetCode, softCode;
	int n_mismatch, n_tests, cyc;

	lv_buck_supervisor #(.OC_TIMEOUT(20), .PERIOD(8), .SS_STEP(4)) dut (
		.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq),
		.activeState(activeState), .seqStartOk(seqStartOk),
		.supplyDetect(supplyDetect), .peakLimit(peakLimit),
		.lsOvercurrent(lsOvercurrent), .overtempWarn(overtempWarn),
		.overtempShutdown(overtempShutdown), .sharedSync(sharedSync),
		.extSyncIn(extSyncIn), .hsOn(hsOn), .regEnable(regEnable),
		.targetCode(targetCode), .softCode(softCode),
		.thermalShutdownEvent(tsdEvent));

	host_model #(.SETTLE(4)) host (.mclk(mclk), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// The run is a few hundred cycles; this ceiling only catches a hang.
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 8000) begin
			n_mismatch++;
			report_and_stop;
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rdChk(input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host.rd(a, d);
		check(d, exp);
	endtask

	task automatic doReset(input logic det);
		rst_n <= 1'b0;
		supplyDetect <= det;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
	endtask

	task automatic testRegsAndRamp;
		int n;
		rdChk(lv_buck_pkg::ADDR_DETECT, 8'h01);
		rdChk(MK, lv_buck_pkg::MASK_RESET);
		rdChk(lv_buck_pkg::ADDR_CTRL, lv_buck_pkg::CTRL_RESET);
		rdChk(4'hf, 8'h00);
		for (n = 0; n < 40 && regEnable !== 1'b1; n++) @(posedge mclk);
		check(8'(softCode < lv_buck_pkg::VCODE_RESET), 8'h01);
		for (n = 0; n < 200 && softCode !== 8'h07; n++) @(posedge mclk);
		check(softCode, lv_buck_pkg::VCODE_RESET);
	endtask

	task automatic testPeak;
		int n;
		for (n = 0; n < 30 && hsOn !== 1'b1; n++) @(posedge mclk);
		check(8'(hsOn), 8'h01);
		peakLimit <= 1'b1;
		repeat (3) @(posedge mclk);
		check(8'(hsOn), 8'h00);
		rdChk(ST, 8'h00);
		repeat (25) @(posedge mclk);
		rdChk(ST, 8'h01);
		check(8'(irq), 8'h01);
		host.wr(ST, 8'h01);
		rdChk(ST, 8'h01);
		peakLimit <= 1'b0;
		host.wr(ST, 8'h01);
		rdChk(ST, 8'h00);
		check(8'(irq), 8'h00);
	endtask

	task automatic testValley;
		int n, k;
		lsOvercurrent <= 1'b1;
		repeat (16) @(posedge mclk);
		k = 0;
		repeat (16) begin
			@(posedge mclk);
			k += hsOn;
		end
		check(8'(k), 8'h00);
		lsOvercurrent <= 1'b0;
		for (n = 0; n < 30 && hsOn !== 1'b1; n++) @(posedge mclk);
		check(8'(hsOn), 8'h01);
		host.wr(ST, 8'h0f);
	endtask

	task automatic testWarn;
		overtempWarn <= 1'b1;
		repeat (3) @(posedge mclk);
		rdChk(LV, 8'h01);
		rdChk(ST, 8'h02);
		check(8'(irq), 8'h01);
		host.wr(MK, 8'h00);
		check(8'(irq), 8'h00);
		host.wr(MK, 8'h0f);
		overtempWarn <= 1'b0;
		repeat (3) @(posedge mclk);
		rdChk(LV, 8'h00);
		rdChk(ST, 8'h02);
		host.wr(ST, 8'h02);
		rdChk(ST, 8'h00);
	endtask

	task automatic testShutdown;
		int n, k;
		overtempShutdown <= 1'b1;
		k = 0;
		repeat (6) begin
			@(posedge mclk);
			k += tsdEvent;
		end
		check(8'(k), 8'h01);
		check({6'h00, regEnable, hsOn}, 8'h00);
		rdChk(ST, 8'h0c);
		overtempShutdown <= 1'b0;
		for (n = 0; n < 60 && regEnable !== 1'b1; n++) @(posedge mclk);
		check(8'(regEnable), 8'h01);
		rdChk(ST, 8'h0c);
		host.wr(ST, 8'h0c);
		rdChk(ST, 8'h00);
	endtask

	task automatic testVoltage;
		host.step(8'h08);
		check(targetCode, 8'h08);
		rdChk(lv_buck_pkg::ADDR_VSETN, 8'hf7);
		host.step(8'h09);
		check(targetCode, lv_buck_pkg::VCODE_MAX);
		activeState <= 1'b0;
		host.step(8'h07);
		check(targetCode, 8'h08);
		activeState <= 1'b1;
		host.step(8'h07);
		rdChk(lv_buck_pkg::ADDR_VSET, 8'h07);
	endtask

	// The selected source restarts the period, the other one is ignored,
	// and without a restart the period still wraps after PERIOD cycles.
	task automatic syncCheck(input logic ext);
		peakLimit <= 1'b1;
		@(posedge mclk);
		peakLimit <= 1'b0;
		sharedSync <= ~ext;
		extSyncIn <= ext;
		@(posedge mclk);
		sharedSync <= 1'b0;
		extSyncIn <= 1'b0;
		@(posedge mclk);
		check(8'(hsOn), 8'h01);
		peakLimit <= 1'b1;
		@(posedge mclk);
		peakLimit <= 1'b0;
		sharedSync <= ext;
		extSyncIn <= ~ext;
		@(posedge mclk);
		sharedSync <= 1'b0;
		extSyncIn <= 1'b0;
		repeat (5) @(posedge mclk);
		check(8'(hsOn), 8'h00);
		@(posedge mclk);
		check(8'(hsOn), 8'h01);
	endtask

	task automatic testSync;
		int n;
		syncCheck(1'b0);
		host.wr(lv_buck_pkg::ADDR_CTRL, 8'h03);
		syncCheck(1'b1);
		host.wr(lv_buck_pkg::ADDR_CTRL, 8'h00);
		@(posedge mclk);
		check(8'(regEnable), 8'h00);
		host.wr(lv_buck_pkg::ADDR_CTRL, lv_buck_pkg::CTRL_RESET);
		seqStartOk <= 1'b0;
		repeat (2) @(posedge mclk);
		check(8'(regEnable), 8'h00);
		seqStartOk <= 1'b1;
		for (n = 0; n < 10 && regEnable !== 1'b1; n++) @(posedge mclk);
		check(8'(regEnable), 8'h01);
	endtask

	task automatic testUnused;
		int k;
		doReset(1'b0);
		rdChk(lv_buck_pkg::ADDR_DETECT, 8'h00);
		overtempWarn <= 1'b1;
		peakLimit <= 1'b1;
		k = 0;
		repeat (40) begin
			@(posedge mclk);
			k += regEnable + hsOn;
		end
		check(8'(k), 8'h00);
		rdChk(ST, 8'h00);
		check(8'(irq), 8'h00);
	endtask

	initial begin
		rst_n = 1'b0;
		activeState = 1'b1;
		seqStartOk = 1'b1;
		supplyDetect = 1'b1;
		peakLimit = 1'b0;
		lsOvercurrent = 1'b0;
		overtempWarn = 1'b0;
		overtempShutdown = 1'b0;
		sharedSync = 1'b0;
		extSyncIn = 1'b0;
		n_mismatch = 0;
		n_tests = 0;
		cyc = 0;
		@(posedge mclk);
		doReset(1'b1);
		testRegsAndRamp;
		testPeak;
		testValley;
		testWarn;
		testShutdown;
		testVoltage;
		testSync;
		testUnused;
		report_and_stop;
	end
endmodule // test_lv_buck_supervisor
